// ===== design/dpc_map.svh
// Register offsets, field positions, reset values and divider counts
`ifndef DPC_MAP_SVH
`define DPC_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets in the special-function-register space
// ----------------------------------------------------------------------
`define DPC_ADDR_CTRL   8'hAE
`define DPC_ADDR_C0L    8'hB1
`define DPC_ADDR_C0H    8'hB2
`define DPC_ADDR_C1L    8'hB3
`define DPC_ADDR_C1H    8'hB4

// ----------------------------------------------------------------------
// Control field positions and reset values
// ----------------------------------------------------------------------
`define DPC_MODE_LSB    4
`define DPC_PRE_LSB     2
`define DPC_SRC_LSB     0
`define DPC_CTRL_RST    8'h00
`define DPC_CMP_RST     8'h00
`define DPC_UNMAPPED    8'h00

// ----------------------------------------------------------------------
// Divider terminal counts (divisor minus one)
// ----------------------------------------------------------------------
`define DPC_XTAL_LAST   4'hE
`define DPC_PRE_LAST1   6'h00
`define DPC_PRE_LAST4   6'h03
`define DPC_PRE_LAST16  6'h0F
`define DPC_PRE_LAST64  6'h3F
`define DPC_LAST_8BIT   16'h00FF
`define DPC_LAST_16BIT  16'hFFFF

`endif

// ===== design/dpc_pkg.sv
// Types shared by the dual-output modulator files
package dpc_pkg;

	// Operating modes of the three-bit mode field
	typedef enum logic [2:0]
	{
		DPC_OFF    = 3'h0,
		DPC_SINGLE = 3'h1,
		DPC_TWIN8  = 3'h2,
		DPC_TWIN16 = 3'h3,
		DPC_NRZ16  = 3'h4,
		DPC_DUAL8  = 3'h5,
		DPC_RZ16   = 3'h6,
		DPC_HOLD   = 3'h7
	} dpc_mode_t;

	// Control register layout
	typedef struct packed
	{
		logic      spare;
		dpc_mode_t mode;
		logic [1:0] pre;
		logic [1:0] src;
	} dpc_ctrl_t;

	// Whole state of the modulator
	typedef struct packed
	{
		dpc_ctrl_t        ctrl;
		logic [7:0]       c0l;
		logic [7:0]       c0h;
		logic [7:0]       c1l;
		logic [7:0]       c1h;
		logic [7:0]       hold0;
		logic [7:0]       hold1;
		logic [7:0]       rdata;
		logic [15:0]      act0;
		logic [15:0]      act1;
		logic [15:0]      cnt;
		logic [15:0]      acc0;
		logic [15:0]      acc1;
		logic [15:0]      gap;
		logic [15:0]      half;
		logic [2:0][2:0]  sy;
		logic [2:0]       lvl;
		logic [3:0]       xdiv;
		logic             src_tick;
		logic             out0;
		logic             out1;
		logic             en0;
		logic             en1;
	} dpc_state_t;

	// State of the prescaler
	typedef struct packed
	{
		logic [5:0] cnt;
		logic       tick;
	} dpc_pre_state_t;

endpackage

// ===== design/dpc_prescaler.sv
// Tick prescaler dividing a source tick by 1, 4, 16 or 64
`timescale 1ns/1ps
`include "dpc_map.svh"

module dpc_prescaler
(
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	input  wire logic       clr_i,
	input  wire logic       tick_i,
	input  wire logic [1:0] code_i,
	output logic            tick_o
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	dpc_pkg::dpc_pre_state_t q;      // Registered state
	dpc_pkg::dpc_pre_state_t next_q; // Next state
	logic [5:0]              last;   // Terminal count for the code

	// Next-state logic
	always_comb
	begin
		next_q = q;
		next_q.tick = 1'b0;
		case (code_i)
			2'h0:    last = `DPC_PRE_LAST1;
			2'h1:    last = `DPC_PRE_LAST4;
			2'h2:    last = `DPC_PRE_LAST16;
			default: last = `DPC_PRE_LAST64;
		endcase
		if (clr_i)
		begin
			next_q.cnt = 6'h00;
		end
		else if (tick_i)
		begin
			// One output tick per divisor input ticks
			if (q.cnt >= last) // R4
			begin
				next_q.cnt = 6'h00;
				next_q.tick = 1'b1;
			end
			else
			begin
				next_q.cnt = q.cnt + 6'h01;
			end
		end
	end

	// State register
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			q <= '0;
		else
			q <= next_q;
	end

	assign tick_o = q.tick;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	property p_div4_spacing;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(tick_o && code_i == 2'h1 && !clr_i) |=>
			(!tick_o || code_i != 2'h1) [*3];
	endproperty
	a_div4_spacing: assert property (p_div4_spacing) // R4
		else $error("divide-by-4 ticks too close");

endmodule

// ===== design/dpc_top.sv
// Dual-output pulse-width and pulse-density modulator
`timescale 1ns/1ps
`include "dpc_map.svh"
//
// Summary of operation
// [R1] Modes 0-3: off, single16, twin8, twin16
// [R2] Modes 4-6: NRZ density, dual8, RZ density
// [R3] Mode 7 holds counter reset, outputs undriven
// [R4] Prescaler divides by 1, 4, 16, 64
// [R5] Source: crystal/15, crystal, pin, PLL
// [R6] Control write restarts the modulation counter
// [R7] 16-bit modes: low write goes to holding
// [R8] High write loads high and held low
// [R9] New 16-bit value applies next cycle only
// [R10] Software writes low byte before high byte
// [R11] Software sets control before using compares
// [R12] Four 8-bit compare registers, read/write, zero
// [R13] Control clears to zero, top bit unimplemented
// [R14] Single mode: second pair period, first duty
// [R15] Twin 8-bit: second low sets period
// [R16] Twin 16-bit: high below compare, low after
// [R17] Density modes: high compare clocks per 65536
// [R18] Counter advances per prescaled tick; pin synchronised
// [R19] Disabled: compare writes apply on next enable

module dpc_top
(
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	input  wire logic       sfr_wr_i,
	input  wire logic [7:0] sfr_addr_i,
	input  wire logic [7:0] sfr_wdata_i,
	input  wire logic       crystal_clock_i,
	input  wire logic       external_count_clock_input_i,
	input  wire logic       pll_oscillator_clock_i,
	output logic [7:0]      sfr_rdata_o,
	output logic            first_modulated_output_o,
	output logic            first_modulated_output_oe_o,
	output logic            second_modulated_output_o,
	output logic            second_modulated_output_oe_o
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	dpc_pkg::dpc_state_t q;        // Registered state
	dpc_pkg::dpc_state_t next_q;   // Next state
	logic                pre_tick; // Prescaled counter tick
	logic                ctrl_wr;  // Control register written
	logic [2:0]          raw;      // Asynchronous clock inputs
	logic [2:0]          rise;     // Qualified rising edges
	logic                xdiv_tick;
	logic                m16;      // A 16-bit mode is selected
	logic                run;      // Generation enabled
	logic                end_cyc;  // Last count of the cycle
	logic [15:0]         last;     // Terminal count of the cycle
	logic [16:0]         sum0;     // Density accumulator sums
	logic [16:0]         sum1;

	assign ctrl_wr = sfr_wr_i && (sfr_addr_i == `DPC_ADDR_CTRL);
	assign raw = {pll_oscillator_clock_i, external_count_clock_input_i,
		crystal_clock_i};

	// ------------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------------
	dpc_prescaler u_pre
	(
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.clr_i   (ctrl_wr),
		.tick_i  (q.src_tick),
		.code_i  (q.ctrl.pre),
		.tick_o  (pre_tick)
	);

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb
	begin
		next_q = q;
		rise = 3'h0;
		xdiv_tick = 1'b0;
		run = (q.ctrl.mode != dpc_pkg::DPC_OFF)
			&& (q.ctrl.mode != dpc_pkg::DPC_HOLD);
		m16 = (q.ctrl.mode == dpc_pkg::DPC_SINGLE)
			|| (q.ctrl.mode == dpc_pkg::DPC_TWIN16)
			|| (q.ctrl.mode == dpc_pkg::DPC_NRZ16)
			|| (q.ctrl.mode == dpc_pkg::DPC_RZ16);

		// Three-stage synchronisers; level taken once stages 2 and 3 agree
		for (int i = 0; i < 3; i++)
		begin
			next_q.sy[i] = {q.sy[i][1:0], raw[i]}; // R18
			if (q.sy[i][1] == q.sy[i][2])
			begin
				next_q.lvl[i] = q.sy[i][2];
				rise[i] = q.sy[i][2] && !q.lvl[i];
			end
		end

		// Crystal divided by fifteen
		if (rise[0])
		begin
			if (q.xdiv == `DPC_XTAL_LAST)
			begin
				next_q.xdiv = 4'h0;
				xdiv_tick = 1'b1;
			end
			else
			begin
				next_q.xdiv = q.xdiv + 4'h1;
			end
		end

		// Counter clock source select
		case (q.ctrl.src)
			2'h0:    next_q.src_tick = xdiv_tick; // R5
			2'h1:    next_q.src_tick = rise[0];   // R5
			2'h2:    next_q.src_tick = rise[1];   // R5
			default: next_q.src_tick = rise[2];   // R5
		endcase

		// Terminal count per mode
		case (q.ctrl.mode)
			dpc_pkg::DPC_SINGLE: last = q.act1 - 16'h0001; // R14
			dpc_pkg::DPC_TWIN8:  last = {8'h00, q.c1l};    // R15
			dpc_pkg::DPC_DUAL8:  last = `DPC_LAST_8BIT;
			default:             last = `DPC_LAST_16BIT;
		endcase
		end_cyc = run && pre_tick && (q.cnt == last);

		// Modulation counter and gap timer
		sum0 = {1'b0, q.acc0} + {1'b0, q.act0};
		sum1 = {1'b0, q.acc1} + {1'b0, q.act1};
		if (!run)
		begin
			next_q.cnt = 16'h0000; // R3
			next_q.acc0 = 16'h0000;
			next_q.acc1 = 16'h0000;
		end
		else if (pre_tick)
		begin
			next_q.cnt = end_cyc ? 16'h0000 : q.cnt + 16'h0001; // R18
			next_q.acc0 = sum0[15:0];
			next_q.acc1 = sum1[15:0];
		end
		if (pre_tick)
		begin
			next_q.gap = 16'h0000;
			next_q.half = {1'b0, q.gap[15:1]};
		end
		else if (q.gap != 16'hFFFF)
		begin
			next_q.gap = q.gap + 16'h0001;
		end

		// Register writes
		if (sfr_wr_i)
		begin
			case (sfr_addr_i)
				`DPC_ADDR_CTRL:
				begin
					// Top bit unimplemented
					next_q.ctrl = dpc_pkg::dpc_ctrl_t'(
						{1'b0, sfr_wdata_i[6:0]}); // R13
					next_q.cnt = 16'h0000; // R6
					next_q.acc0 = 16'h0000;
					next_q.acc1 = 16'h0000;
				end
				`DPC_ADDR_C0L:
				begin
					if (m16)
						next_q.hold0 = sfr_wdata_i; // R7
					else
						next_q.c0l = sfr_wdata_i; // R12
				end
				`DPC_ADDR_C1L:
				begin
					if (m16)
						next_q.hold1 = sfr_wdata_i; // R7
					else
						next_q.c1l = sfr_wdata_i; // R12
				end
				`DPC_ADDR_C0H:
				begin
					next_q.c0h = sfr_wdata_i; // R12
					if (m16)
						next_q.c0l = q.hold0; // R8
				end
				`DPC_ADDR_C1H:
				begin
					next_q.c1h = sfr_wdata_i; // R12
					if (m16)
						next_q.c1l = q.hold1; // R8
				end
				default:
				begin
					// Other addresses belong to other blocks
				end
			endcase
		end

		// Active compare values: immediate when idle or on a control write, else at cycle end
		if (!run || ctrl_wr)
		begin
			next_q.act0 = {q.c0h, q.c0l}; // R19
			next_q.act1 = {q.c1h, q.c1l}; // R19
		end
		else if (end_cyc)
		begin
			next_q.act0 = {q.c0h, q.c0l}; // R9
			next_q.act1 = {q.c1h, q.c1l}; // R9
		end

		// Output waveforms per mode
		next_q.en0 = run; // R1
		next_q.en1 = run && (q.ctrl.mode != dpc_pkg::DPC_SINGLE); // R1
		case (q.ctrl.mode)
			dpc_pkg::DPC_SINGLE:
			begin
				next_q.out0 = next_q.cnt < next_q.act0; // R14
				next_q.out1 = 1'b0;
			end
			dpc_pkg::DPC_TWIN8:
			begin
				next_q.out0 = next_q.cnt[7:0] < q.c0l; // R1
				next_q.out1 = (next_q.cnt[7:0] >= q.c1h)
					&& (next_q.cnt[7:0] < q.c0h); // R1
			end
			dpc_pkg::DPC_TWIN16:
			begin
				next_q.out0 = next_q.cnt < next_q.act0; // R16
				next_q.out1 = next_q.cnt < next_q.act1; // R16
			end
			dpc_pkg::DPC_DUAL8:
			begin
				next_q.out0 = next_q.cnt[7:0] < q.c0l; // R2
				next_q.out1 = next_q.cnt[7:0] < q.c0h; // R2
			end
			dpc_pkg::DPC_NRZ16, dpc_pkg::DPC_RZ16:
			begin
				if (pre_tick && !ctrl_wr)
				begin
					next_q.out0 = sum0[16]; // R17
					next_q.out1 = sum1[16]; // R17
				end
				else if (ctrl_wr)
				begin
					next_q.out0 = 1'b0;
					next_q.out1 = 1'b0;
				end
				else if (q.ctrl.mode == dpc_pkg::DPC_RZ16
					&& q.gap == q.half)
				begin
					// Return to zero halfway through the tick
					next_q.out0 = 1'b0; // R2
					next_q.out1 = 1'b0; // R2
				end
			end
			default:
			begin
				next_q.out0 = 1'b0; // R3
				next_q.out1 = 1'b0; // R3
			end
		endcase

		// Registered read data, zero for addresses not mapped here
		case (sfr_addr_i)
			`DPC_ADDR_CTRL: next_q.rdata = q.ctrl;
			`DPC_ADDR_C0L:  next_q.rdata = q.c0l;
			`DPC_ADDR_C0H:  next_q.rdata = q.c0h;
			`DPC_ADDR_C1L:  next_q.rdata = q.c1l;
			`DPC_ADDR_C1H:  next_q.rdata = q.c1h;
			default:        next_q.rdata = `DPC_UNMAPPED;
		endcase
	end

	// State register; all fields clear at power-on
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			q <= '0; // R12 R13
		else
			q <= next_q;
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign sfr_rdata_o = q.rdata;
	assign first_modulated_output_o = q.out0;
	assign first_modulated_output_oe_o = q.en0;
	assign second_modulated_output_o = q.out1;
	assign second_modulated_output_oe_o = q.en1;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	property p_hold_quiet;
		q.ctrl.mode == dpc_pkg::DPC_HOLD |=> !first_modulated_output_oe_o
			&& !second_modulated_output_oe_o && q.cnt == 16'h0000;
	endproperty
	a_hold_quiet: assert property (p_hold_quiet) // R3
		else $error("mode 7 drives outputs or counts");

	property p_ctrl_restart;
		ctrl_wr |=> q.cnt == 16'h0000 && q.acc0 == 16'h0000;
	endproperty
	a_ctrl_restart: assert property (p_ctrl_restart) // R6
		else $error("control write did not restart counter");

	property p_ctrl_value;
		ctrl_wr |=> q.ctrl == {1'b0, $past(sfr_wdata_i[6:0])}
			&& !q.ctrl.spare;
	endproperty
	a_ctrl_value: assert property (p_ctrl_value) // R13
		else $error("control value or top bit wrong");

	property p_low_held;
		m16 && sfr_wr_i && sfr_addr_i == `DPC_ADDR_C0L |=>
			q.hold0 == $past(sfr_wdata_i) && $stable(q.c0l);
	endproperty
	a_low_held: assert property (p_low_held) // R7
		else $error("low byte not captured in holding");

	property p_high_pair;
		m16 && sfr_wr_i && sfr_addr_i == `DPC_ADDR_C0H |=>
			q.c0l == $past(q.hold0) && q.c0h == $past(sfr_wdata_i);
	endproperty
	a_high_pair: assert property (p_high_pair) // R8
		else $error("high write did not load pair");

	property p_act_stable;
		run && m16 && !end_cyc && !ctrl_wr |=> $stable(q.act0)
			&& $stable(q.act1);
	endproperty
	a_act_stable: assert property (p_act_stable) // R9
		else $error("compare changed inside a cycle");

	property p_single_out;
		q.ctrl.mode == dpc_pkg::DPC_SINGLE
			&& $past(q.ctrl.mode) == dpc_pkg::DPC_SINGLE |->
			first_modulated_output_o == (q.cnt < q.act0)
			&& !second_modulated_output_oe_o;
	endproperty
	a_single_out: assert property (p_single_out) // R1 R14
		else $error("single mode output wrong");

	property p_twin16_out;
		q.ctrl.mode == dpc_pkg::DPC_TWIN16
			&& $past(q.ctrl.mode) == dpc_pkg::DPC_TWIN16 |->
			first_modulated_output_o == (q.cnt < q.act0)
			&& second_modulated_output_o == (q.cnt < q.act1);
	endproperty
	a_twin16_out: assert property (p_twin16_out) // R16
		else $error("twin 16-bit outputs wrong");

	property p_idle_load;
		!run && !ctrl_wr |=> q.act0 == $past({q.c0h, q.c0l});
	endproperty
	a_idle_load: assert property (p_idle_load) // R19
		else $error("idle compare not applied");

	c_twin16_fall: cover property (q.ctrl.mode == dpc_pkg::DPC_TWIN16
		&& $fell(first_modulated_output_o));
	c_nrz_high: cover property (q.ctrl.mode == dpc_pkg::DPC_NRZ16
		&& second_modulated_output_o);
	c_rz_pulse: cover property (q.ctrl.mode == dpc_pkg::DPC_RZ16
		&& $fell(first_modulated_output_o));
	c_end_cycle: cover property (end_cyc && m16);

endmodule

// ===== dv/tb_dpc_top.sv
// Self-checking bench for the dual-output modulator
`timescale 1ns/1ps
`include "dpc_map.svh"

module tb_dpc_top;
	// --------------------------------------------------------------
	// Stimulus, observed outputs and bookkeeping
	// --------------------------------------------------------------
	logic        mclk_i  = 1'b0;        // Core clock
	logic        rst_n_i = 1'b0;        // Reset, active low
	logic        wr      = 1'b0;        // Write strobe
	logic [7:0]  addr    = 8'h00;       // Register address
	logic [7:0]  wdata   = 8'h00;       // Write data
	logic        slow    = 1'b0;        // Count clock, 8 core cycles
	logic        pin     = 1'b0;        // Pin clock, 16 core cycles
	logic [2:0]  sdiv    = 3'h0;        // Divider for the count clocks
	logic [7:0]  rdata;                 // Read data
	logic        out0;                  // First output
	logic        oe0;                   // First output enable
	logic        out1;                  // Second output
	logic        oe1;                   // Second output enable
	logic [31:0] lfsr    = 32'h42132DEE; // Random state
	logic [7:0]  q_rd[$];               // Expected read data
	logic [1:0]  q_oe[$];               // Expected enables
	int          q_w[$];                // Expected high widths
	int          mismatches = 0;        // Failed comparisons
	int          n_compared = 0;        // All comparisons
	bit          meas = 1'b0;           // Width measuring on
	bit          sel1 = 1'b0;           // Measure the second output
	logic        mon;                   // Output being measured
	int          run = 0;               // Cycles high so far
	event        ev_rd;                 // Read data settled
	event        ev_oe;                 // Enables settled
	logic [7:0]  regs[5] = '{`DPC_ADDR_CTRL, `DPC_ADDR_C0L,
		`DPC_ADDR_C0H, `DPC_ADDR_C1L, `DPC_ADDR_C1H};
	logic [7:0]  shadow[5];             // Expected register contents
	// Waveform table: control, compares, high width, output measured
	logic [7:0]  t_ctrl[13] = '{8'h13, 8'h17, 8'h1B, 8'h1F, 8'h11,
		8'h12, 8'h10, 8'h23, 8'h53, 8'h43, 8'h63, 8'h23, 8'h43};
	logic [15:0] t_c0[13] = '{16'h0005, 16'h0005, 16'h0005, 16'h0005,
		16'h0005, 16'h0005, 16'h0005, 16'h0003, 16'h0003, 16'h8000,
		16'h8000, 16'h0503, 16'h0000};
	logic [15:0] t_c1[13] = '{16'h0010, 16'h0010, 16'h0010, 16'h0010,
		16'h0010, 16'h0010, 16'h0010, 16'h000F, 16'h0000, 16'h0000,
		16'h0000, 16'h020F, 16'h4000};
	int          t_w[13] = '{40, 160, 640, 2560, 40, 80, 600, 24, 24,
		8, 4, 24, 8};
	bit          t_s[13] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1};

	dpc_top u_dpc_top
	(
		.mclk_i                       (mclk_i),
		.rst_n_i                      (rst_n_i),
		.sfr_wr_i                     (wr),
		.sfr_addr_i                   (addr),
		.sfr_wdata_i                  (wdata),
		.crystal_clock_i              (slow),
		.external_count_clock_input_i (pin),
		.pll_oscillator_clock_i       (slow),
		.sfr_rdata_o                  (rdata),
		.first_modulated_output_o     (out0),
		.first_modulated_output_oe_o  (oe0),
		.second_modulated_output_o    (out1),
		.second_modulated_output_oe_o (oe1)
	);

	// --------------------------------------------------------------
	// Clocks: core clock, a shared count clock and a slower pin clock
	// --------------------------------------------------------------
	always #5 mclk_i = ~mclk_i;

	// Count clock toggles every four core cycles, pin clock every eight
	always @(posedge mclk_i)
	begin
		sdiv <= sdiv + 3'h1;
		if (sdiv[1:0] == 2'h3)
			slow <= ~slow;
		if (sdiv == 3'h7)
			pin <= ~pin;
	end

	// Output whose high pulses are measured
	assign mon = sel1 ? out1 : out0;

	// --------------------------------------------------------------
	// Comparison helpers
	// --------------------------------------------------------------
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Print one mismatch and count it
	task automatic report(string what, logic [15:0] e, logic [15:0] g);
		$display("unexpected %s: expected %h seen %h", what, e, g);
		mismatches++;
	endtask

	task automatic chk_rd(logic [7:0] e, logic [7:0] g);
		n_compared++;
		if (g !== e)
			report("read data", {8'h00, e}, {8'h00, g});
	endtask

	task automatic chk_oe(logic [1:0] e, logic [1:0] g);
		n_compared++;
		if (g !== e)
			report("output enables", {14'h0000, e}, {14'h0000, g});
	endtask

	task automatic chk_width(int e, int g);
		n_compared++;
		if (g != e)
			report("high width", e[15:0], g[15:0]);
	endtask

	// --------------------------------------------------------------
	// Monitors take the oldest note when a result appears
	// --------------------------------------------------------------
	always @(ev_rd)
		chk_rd(q_rd.pop_front(), rdata);

	always @(ev_oe)
		chk_oe(q_oe.pop_front(), {oe1, oe0});

	// Measure whole high pulses of the selected output
	always @(posedge mclk_i)
	begin
		if (meas && mon === 1'b1)
			run <= run + 1;
		else if (meas && run > 0)
		begin
			chk_width(q_w.pop_front(), run);
			run <= 0;
		end
	end

	// --------------------------------------------------------------
	// Bus tasks
	// --------------------------------------------------------------
	task automatic wr_reg(logic [7:0] a, logic [7:0] d);
		@(posedge mclk_i);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge mclk_i);
		wr    <= 1'b0;
	endtask

	// Read data is registered one cycle after the address
	task automatic rd_reg(logic [7:0] a, logic [7:0] e);
		@(posedge mclk_i);
		addr <= a;
		@(posedge mclk_i);
		#1;
		q_rd.push_back(e);
		-> ev_rd;
	endtask

	task automatic give_verdict;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Cut a hang short
	initial
	begin
		repeat (60000) @(posedge mclk_i);
		mismatches++;
		give_verdict();
	end

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		// Reset values, then an unmapped address
		for (int i = 0; i < 5; i++)
			rd_reg(regs[i], 8'h00);
		rd_reg(8'h00, 8'h00);
		// Random compare values written and read back while disabled
		for (int i = 1; i < 5; i++)
		begin
			lfsr = next_rand(lfsr);
			shadow[i] = lfsr[7:0];
			wr_reg(regs[i], shadow[i]);
		end
		for (int i = 1; i < 5; i++)
			rd_reg(regs[i], shadow[i]);
		// Top control bit is not kept
		wr_reg(`DPC_ADDR_CTRL, 8'hFF);
		rd_reg(`DPC_ADDR_CTRL, 8'h7F);
		// Low byte waits in holding until the high byte is written
		wr_reg(`DPC_ADDR_CTRL, 8'h33);
		wr_reg(`DPC_ADDR_C0L, 8'hA5);
		rd_reg(`DPC_ADDR_C0L, shadow[1]);
		wr_reg(`DPC_ADDR_C0H, 8'h5A);
		rd_reg(`DPC_ADDR_C0L, 8'hA5);
		rd_reg(`DPC_ADDR_C0H, 8'h5A);
		// Every mode code and the enables it gives
		for (int m = 0; m < 8; m++)
		begin
			wr_reg(`DPC_ADDR_CTRL, {1'b0, m[2:0], 4'h3});
			repeat (2) @(posedge mclk_i);
			#1;
			q_oe.push_back({m > 1 && m < 7, m > 0 && m < 7});
			-> ev_oe;
		end
		// Waveforms: configure while disabled, then start the mode
		for (int k = 0; k < 13; k++)
		begin
			wr_reg(`DPC_ADDR_CTRL, 8'h00);
			wr_reg(`DPC_ADDR_C0L, t_c0[k][7:0]);
			wr_reg(`DPC_ADDR_C0H, t_c0[k][15:8]);
			wr_reg(`DPC_ADDR_C1L, t_c1[k][7:0]);
			wr_reg(`DPC_ADDR_C1H, t_c1[k][15:8]);
			// Outputs are low while disabled, so the switch is clean
			sel1 = t_s[k];
			wr_reg(`DPC_ADDR_CTRL, t_ctrl[k]);
			@(negedge mon);
			q_w.push_back(t_w[k]);
			meas = 1'b1;
			while (q_w.size() != 0)
				@(posedge mclk_i);
			meas = 1'b0;
		end
		give_verdict();
	end
endmodule
